// ### rtl/mprc_pkg.sv
// constants, field layout and state type of the program run-control block
// assumes one 250 MHz clock and a plain register port from the host side
// Function
// - manual mode: jog accepted, cycle start ignored
// - pause held: start needs release and new rise
// - pause suspends; resume on release plus start
// - forced end held: start needs release, rise
// - start and forced end together: no run
// - start falling beats simultaneous forced end
// - forced end cancels block, stops; start restarts
// - no restart while forced end still high
// - forced end between blocks cancels next block
// - pause held: start plus forced end ignored
// - forced end beats simultaneous pause
// - forced end ignored while paused
// - leaving auto stops program; pause then ignored
// - leaving auto stops; later forced end ignored
// - paused then auto low enters manual
// - forced-end stop then auto low enters manual
// - single block: forced end stops, start continues
// - aux reset already high skips aux output
// - aux wait ignores start; reset fall resamples start
// - forced end beats aux reset, clears code
// - pause keeps aux code, ignores aux reset
package mprc_pkg;

  // ==================================================================
  // register map
  localparam logic [3:0] MPRC_CTRL_OFS = 4'h0;
  localparam logic [3:0] MPRC_STAT_OFS = 4'h4;
  localparam logic [3:0] MPRC_AUX_OFS = 4'h8;
  localparam logic [31:0] MPRC_CTRL_RST = 32'h0000_0000;

  // ==================================================================
  // control bit positions
  localparam int MPRC_NCTL = 7;
  localparam int MPRC_B_AUTO = 0;
  localparam int MPRC_B_START = 1;
  localparam int MPRC_B_PAUSE = 2;
  localparam int MPRC_B_FEND = 3;
  localparam int MPRC_B_SINGLE = 4;
  localparam int MPRC_B_JOG = 5;
  localparam int MPRC_B_AUXRST = 6;

  // ==================================================================
  // status bit positions
  localparam int MPRC_S_MANUAL = 0;
  localparam int MPRC_S_RUN = 1;
  localparam int MPRC_S_PAUSED = 2;
  localparam int MPRC_S_AUXWAIT = 3;
  localparam int MPRC_S_HOLD = 4;
  localparam int MPRC_S_JOG = 5;
  localparam int MPRC_S_AUXVAL = 6;

  // ==================================================================
  // timing
  localparam int MPRC_CLK_PERIOD_PS = 4000;
  localparam int MPRC_SCAN_TIME_NS = 1000;
  localparam int MPRC_SCAN_CYCLES = (MPRC_SCAN_TIME_NS * 1000) / MPRC_CLK_PERIOD_PS;
  localparam int MPRC_AUX_W = 8;
  localparam logic [MPRC_AUX_W-1:0] MPRC_AUX_RST = 8'h00;

  typedef enum logic [2:0] {
    ST_MANUAL,
    ST_IDLE,
    ST_GAP,
    ST_RUN,
    ST_PAUSE,
    ST_AUXW,
    ST_HOLD
  } mprc_state_t;

endpackage

// ### rtl/mprc_scan_div.sv
// scan tick divider: one-cycle enable every scan period
// assumes synchronous reset copy from the top
`timescale 1ns/1ps
module mprc_scan_div #(
  parameter int CYCLES = 250
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);
  localparam int CW = $clog2(CYCLES);

  // ==================================================================
  // sanity
  generate
    if (CYCLES < 2)
    begin : g_chk
      $error("scan period must be two cycles or more");
    end
  endgenerate

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic tick_d;
  logic tick_q;

  always_comb
  begin
    tick_d = (cnt_q == CW'(CYCLES - 1));
    cnt_d = tick_d ? '0 : cnt_q + CW'(1);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule

// ### rtl/mprc_edge.sv
// per-bit scan sampler with rise and fall detection
// assumes inputs already in the clock domain; eval pulses once per scan
`timescale 1ns/1ps
module mprc_edge #(
  parameter int N = 7
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic [N-1:0] din,
  output logic [N-1:0] lvl,
  output logic [N-1:0] rise,
  output logic [N-1:0] fall,
  output logic eval
);
  logic [N-1:0] cur_q;
  logic [N-1:0] prev_q;
  logic eval_q;

  // ==================================================================
  // one sample and its predecessor per bit
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_bit
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          cur_q[i] <= 1'b0;
          prev_q[i] <= 1'b0;
        end
        else if (tick)
        begin
          cur_q[i] <= din[i];
          prev_q[i] <= cur_q[i];
        end
      end
      assign rise[i] = cur_q[i] & ~prev_q[i];
      assign fall[i] = ~cur_q[i] & prev_q[i];
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      eval_q <= 1'b0;
    else
      eval_q <= tick;
  end

  assign lvl = cur_q;
  assign eval = eval_q;
endmodule

// ### rtl/mprc_top.sv
// program run-control: control word from the host, block handshake to the
// motion engine, aux code output. engine signals are on the same clock.
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module mprc_top
  import mprc_pkg::*;
#(
  parameter int SCAN_CYCLES = mprc_pkg::MPRC_SCAN_CYCLES,
  parameter int AUX_W = mprc_pkg::MPRC_AUX_W
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic BLK_DONE,
  input wire logic BLK_LAST,
  input wire logic BLK_AUX,
  input wire logic [AUX_W-1:0] BLK_AUX_CODE,
  output logic BLK_REQ,
  output logic BLK_CANCEL,
  output logic BLK_HOLD,
  output logic RUN_ACTIVE,
  output logic MANUAL_MODE,
  output logic JOG_EN,
  output logic AUX_VALID,
  output logic [AUX_W-1:0] AUX_CODE
);
  import mprc_pkg::*;

  generate
    if (AUX_W < 1 || AUX_W > 32)
    begin : g_chk
      $error("aux code width must be 1 to 32");
    end
  endgenerate

  // ==================================================================
  // reset release
  logic rst_a_q;
  logic rst_n;

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rst_a_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_a_q <= 1'b1;
      rst_n <= rst_a_q;
    end
  end

  // ==================================================================
  // control register
  logic [MPRC_NCTL-1:0] ctrl_q;
  logic [MPRC_NCTL-1:0] ctrl_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [31:0] stat_w;
  logic [AUX_W-1:0] aux_q;

  always_comb
  begin
    ctrl_d = ctrl_q;
    if (WR && ADDR == MPRC_CTRL_OFS)
      ctrl_d = WDATA[MPRC_NCTL-1:0];
    rdata_d = 32'h0000_0000;
    if (RD)
    begin
      unique case (ADDR)
        MPRC_CTRL_OFS: rdata_d = {{(32 - MPRC_NCTL){1'b0}}, ctrl_q};
        MPRC_STAT_OFS: rdata_d = stat_w;
        MPRC_AUX_OFS: rdata_d = 32'(aux_q);
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= MPRC_CTRL_RST[MPRC_NCTL-1:0];
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  assign RDATA = rdata_q;

  // ==================================================================
  // scan sampling
  logic tick;
  logic eval;
  logic [MPRC_NCTL-1:0] lvl;
  logic [MPRC_NCTL-1:0] rise;
  logic [MPRC_NCTL-1:0] fall;

  mprc_scan_div #(
    .CYCLES(SCAN_CYCLES)
  ) u_div (
    .clk(CLK),
    .rst_n(rst_n),
    .tick(tick)
  );

  mprc_edge #(
    .N(MPRC_NCTL)
  ) u_edge (
    .clk(CLK),
    .rst_n(rst_n),
    .tick(tick),
    .din(ctrl_q),
    .lvl(lvl),
    .rise(rise),
    .fall(fall),
    .eval(eval)
  );

  logic auto_l;
  logic pause_l;
  logic fend_l;
  logic single_l;
  logic auxrst_l;
  logic start_l;
  logic start_r;
  logic start_f;
  logic fend_r;
  logic auxrst_f;

  assign auto_l = lvl[MPRC_B_AUTO];
  assign pause_l = lvl[MPRC_B_PAUSE];
  assign fend_l = lvl[MPRC_B_FEND];
  assign single_l = lvl[MPRC_B_SINGLE];
  assign auxrst_l = lvl[MPRC_B_AUXRST];
  assign start_l = lvl[MPRC_B_START];
  assign start_r = rise[MPRC_B_START];
  assign start_f = fall[MPRC_B_START];
  assign fend_r = rise[MPRC_B_FEND];
  assign auxrst_f = fall[MPRC_B_AUXRST];

  // ==================================================================
  // run-control sequencer
  mprc_state_t st_q;
  mprc_state_t st_d;
  logic done_q;
  logic done_d;
  logic last_q;
  logic last_d;
  logic req_q;
  logic req_d;
  logic cancel_q;
  logic cancel_d;
  logic auxv_q;
  logic auxv_d;
  logic [AUX_W-1:0] aux_d;
  logic go;
  logic fend_hit;

  // a fresh start needs a rise with both blockers low in the same scan
  assign go = start_r & ~pause_l & ~fend_l;
  // falling start in the same scan masks a forced end
  assign fend_hit = fend_r & ~start_f;

  always_comb
  begin
    st_d = st_q;
    done_d = done_q | BLK_DONE;
    last_d = BLK_DONE ? BLK_LAST : last_q;
    req_d = 1'b0;
    cancel_d = 1'b0;
    auxv_d = auxv_q;
    aux_d = aux_q;
    // engine completions are caught between scans so none is lost
    if (BLK_DONE && BLK_AUX && st_q == ST_RUN)
      aux_d = BLK_AUX_CODE;
    if (eval)
    begin
      unique case (st_q)
        ST_MANUAL:
        begin
          if (auto_l)
            st_d = ST_IDLE;
        end
        ST_IDLE:
        begin
          if (!auto_l)
            st_d = ST_MANUAL;
          else if (go)
            st_d = ST_GAP;
        end
        ST_GAP:
        begin
          if (!auto_l)
            st_d = ST_MANUAL;
          else if (fend_hit)
          begin
            st_d = ST_IDLE;
            auxv_d = 1'b0;
          end
          else
          begin
            req_d = 1'b1;
            done_d = 1'b0;
            st_d = ST_RUN;
          end
        end
        ST_RUN:
        begin
          if (!auto_l)
          begin
            st_d = ST_MANUAL;
            cancel_d = 1'b1;
          end
          else if (fend_hit)
          begin
            st_d = ST_IDLE;
            cancel_d = 1'b1;
            auxv_d = 1'b0;
          end
          else if (pause_l)
            st_d = ST_PAUSE;
          else if (done_q)
          begin
            done_d = 1'b0;
            if (BLK_AUX && !auxrst_l && aux_q != MPRC_AUX_RST)
            begin
              auxv_d = 1'b1;
              st_d = ST_AUXW;
            end
            else if (last_q)
              st_d = ST_IDLE;
            else if (single_l)
              st_d = ST_HOLD;
            else
              st_d = ST_GAP;
          end
        end
        ST_PAUSE:
        begin
          // forced end and aux reset both ignored here
          if (!auto_l)
            st_d = ST_MANUAL;
          else if (start_r && !pause_l)
            st_d = ST_RUN;
        end
        ST_AUXW:
        begin
          if (!auto_l)
            st_d = ST_MANUAL;
          else if (fend_hit)
          begin
            st_d = ST_IDLE;
            auxv_d = 1'b0;
          end
          else if (auxrst_f)
          begin
            auxv_d = 1'b0;
            // cycle start level only looked at on the release
            if (last_q)
              st_d = ST_IDLE;
            else if (start_l && !single_l)
              st_d = ST_GAP;
            else
              st_d = ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          if (!auto_l)
            st_d = ST_MANUAL;
          else if (fend_hit)
          begin
            st_d = ST_IDLE;
            auxv_d = 1'b0;
          end
          else if (go)
            st_d = ST_GAP;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= ST_IDLE;
      done_q <= 1'b0;
      last_q <= 1'b0;
      req_q <= 1'b0;
      cancel_q <= 1'b0;
      auxv_q <= 1'b0;
      aux_q <= MPRC_AUX_RST;
    end
    else
    begin
      st_q <= st_d;
      done_q <= done_d;
      last_q <= last_d;
      req_q <= req_d;
      cancel_q <= cancel_d;
      auxv_q <= auxv_d;
      aux_q <= aux_d;
    end
  end

  // ==================================================================
  // outputs and status
  logic manual_w;
  logic jog_q;
  logic jog_d;

  assign manual_w = (st_q == ST_MANUAL);

  // jog follows the scan that sees auto low, in the same cycle as the state moves
  always_comb
  begin
    jog_d = jog_q;
    if (eval)
      jog_d = ~auto_l & lvl[MPRC_B_JOG];
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      jog_q <= 1'b0;
    else
      jog_q <= jog_d;
  end

  assign BLK_REQ = req_q;
  assign BLK_CANCEL = cancel_q;
  assign BLK_HOLD = (st_q == ST_PAUSE);
  assign RUN_ACTIVE = (st_q == ST_RUN) || (st_q == ST_GAP);
  assign MANUAL_MODE = manual_w;
  assign JOG_EN = jog_q;
  assign AUX_VALID = auxv_q;
  assign AUX_CODE = auxv_q ? aux_q : MPRC_AUX_RST;

  always_comb
  begin
    stat_w = 32'h0000_0000;
    stat_w[MPRC_S_MANUAL] = manual_w;
    stat_w[MPRC_S_RUN] = RUN_ACTIVE;
    stat_w[MPRC_S_PAUSED] = (st_q == ST_PAUSE);
    stat_w[MPRC_S_AUXWAIT] = (st_q == ST_AUXW);
    stat_w[MPRC_S_HOLD] = (st_q == ST_HOLD);
    stat_w[MPRC_S_JOG] = jog_q;
    stat_w[MPRC_S_AUXVAL] = auxv_q;
  end
endmodule

// ### testbench/mprc_assertions.sv
// concurrent checks on the run-control top ports
// assumes one clock domain and the active-low top reset
`timescale 1ns/1ps
module mprc_checker #(
  parameter int SCAN_CYCLES = 250,
  parameter int AUX_W = 8
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic BLK_REQ,
  input wire logic BLK_CANCEL,
  input wire logic BLK_HOLD,
  input wire logic RUN_ACTIVE,
  input wire logic MANUAL_MODE,
  input wire logic JOG_EN,
  input wire logic AUX_VALID,
  input wire logic [AUX_W-1:0] AUX_CODE
);
  // ==================================================================
  // properties
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  sequence s_wr_ctrl;
    WR && ADDR == 4'h0;
  endsequence
  sequence s_rd_ctrl;
    RD && ADDR == 4'h0;
  endsequence
  a_ctrl_readback: assert property (s_wr_ctrl ##1 s_rd_ctrl |=> RDATA[6:0] == $past(WDATA[6:0], 2))
    else $error("control readback differs");
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data outside answer cycle");
  a_req_cancel_excl: assert property (!(BLK_REQ && BLK_CANCEL))
    else $error("request and cancel together");
  a_cancel_stops_run: assert property (BLK_CANCEL |-> ##[0:1] !RUN_ACTIVE)
    else $error("run continues after cancel");
  a_manual_no_run: assert property (MANUAL_MODE |-> !RUN_ACTIVE)
    else $error("run active in manual mode");
  a_manual_no_req: assert property (MANUAL_MODE |-> !BLK_REQ)
    else $error("block request in manual mode");
  a_jog_in_manual: assert property (JOG_EN |-> MANUAL_MODE || $past(MANUAL_MODE))
    else $error("jog accepted outside manual mode");
  a_hold_no_req: assert property (BLK_HOLD |-> !BLK_REQ)
    else $error("block request while held");
  a_aux_idle_zero: assert property (!AUX_VALID |-> AUX_CODE == '0)
    else $error("aux code shown without valid");
  // decisions come once a scan, so a request is never repeated at once
  a_req_per_scan: assert property (BLK_REQ |=> !BLK_REQ [*3])
    else $error("block requests too close");
endmodule
bind mprc_top mprc_checker #(.SCAN_CYCLES(SCAN_CYCLES), .AUX_W(AUX_W)) u_chk (.CLK(CLK),
  .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .BLK_REQ(BLK_REQ), .BLK_CANCEL(BLK_CANCEL), .BLK_HOLD(BLK_HOLD), .RUN_ACTIVE(RUN_ACTIVE),
  .MANUAL_MODE(MANUAL_MODE), .JOG_EN(JOG_EN), .AUX_VALID(AUX_VALID), .AUX_CODE(AUX_CODE));

// ### testbench/mprc_engine_model.sv
// motion engine model: runs each requested block for a set delay
// assumes the run-control clock; delay and aux settings come from the bench
`timescale 1ns/1ps
module mprc_engine_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic blk_req,
  input wire logic blk_cancel,
  input wire logic blk_hold,
  input wire logic [15:0] delay,
  input wire logic aux,
  input wire logic [7:0] code,
  output logic blk_done,
  output logic blk_last,
  output logic blk_aux,
  output logic [7:0] blk_aux_code
);
  // ==================================================================
  // block timer
  logic busy;
  logic [15:0] cnt;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      cnt <= 16'h0;
      blk_done <= 1'b0;
      blk_aux <= 1'b0;
    end
    else
    begin
      blk_done <= 1'b0;
      if (blk_cancel)
        busy <= 1'b0;
      else if (blk_req)
      begin
        busy <= 1'b1;
        cnt <= delay;
        blk_aux <= aux;
      end
      // motion freezes while held, like a real axis
      else if (busy && !blk_hold)
      begin
        if (cnt == 16'h0)
        begin
          blk_done <= 1'b1;
          busy <= 1'b0;
        end
        else
          cnt <= cnt - 16'h1;
      end
    end
  end
  // qualifiers are only good beside the done pulse; garbage otherwise
  assign blk_last = !blk_done;
  assign blk_aux_code = blk_done ? code : ~code;
endmodule

// ### testbench/tb_mprc_top.sv
// self-checking bench for the run-control block
// assumes the engine model beside it and a short scan period
`timescale 1ns/1ps
module tb_mprc_top;
  import mprc_pkg::*;
  localparam int SC = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic done, last, baux, req, can, hold, run, man, jog, av;
  logic [7:0] bcode, acode;
  logic [15:0] dly = 16'hFFFF;
  logic eaux = 1'b0;
  int err_total = 0;
  int compares = 0;
  int can_n = 0;
  // ==================================================================
  // clock, reset, parts
  initial
  begin
    forever #2 clk = ~clk;
  end
  mprc_top #(.SCAN_CYCLES(SC), .AUX_W(8)) dut (.CLK(clk), .RESETN(rst_n), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .BLK_DONE(done), .BLK_LAST(last),
    .BLK_AUX(baux), .BLK_AUX_CODE(bcode), .BLK_REQ(req), .BLK_CANCEL(can), .BLK_HOLD(hold),
    .RUN_ACTIVE(run), .MANUAL_MODE(man), .JOG_EN(jog), .AUX_VALID(av), .AUX_CODE(acode));
  mprc_engine_model eng (.clk(clk), .rst_n(rst_n), .blk_req(req), .blk_cancel(can),
    .blk_hold(hold), .delay(dly), .aux(eaux), .code(8'h5A), .blk_done(done),
    .blk_last(last), .blk_aux(baux), .blk_aux_code(bcode));
  always @(posedge clk)
  begin
    if (can === 1'b1)
      can_n++;
  end
  // ==================================================================
  // tasks; each is entered just after a rising edge
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrt(input logic [3:0] a, input logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] got;
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
    chk(got, exp);
    @(posedge clk);
  endtask
  // control change held six scans: samples, decision and a short engine block land
  task automatic set(input logic [31:0] d);
    wrt(4'h0, d);
    repeat (6 * SC) @(posedge clk);
  endtask
  // run, manual, jog, hold levels
  task automatic pv(input logic [3:0] e);
    chk({28'h0, run, man, jog, hold}, {28'h0, e});
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop;
  end
  // ==================================================================
  // tests
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    set(32'h22);
    pv(4'h6);
    rdc(4'h4, 32'h21);
    wrt(4'hC, 32'hFF);
    rdc(4'hC, 32'h0);
    wrt(4'h0, 32'h22);
    rdc(4'h0, 32'h22);
    wrt(4'h4, 32'hFF);
    rdc(4'h4, 32'h21);
    set(32'h05);
    set(32'h07);
    pv(4'h0);
    set(32'h03);
    pv(4'h0);
    set(32'h01);
    set(32'h03);
    pv(4'h8);
    rdc(4'h4, 32'h02);
    set(32'h07);
    pv(4'h1);
    set(32'h0F);
    chk(can_n, 0);
    pv(4'h1);
    set(32'h05);
    set(32'h01);
    set(32'h03);
    pv(4'h8);
    set(32'h0B);
    chk(can_n, 1);
    pv(4'h0);
    set(32'h09);
    set(32'h0B);
    pv(4'h0);
    set(32'h01);
    set(32'h13);
    pv(4'h8);
    set(32'h1F);
    chk(can_n, 2);
    pv(4'h0);
    set(32'h01);
    set(32'h0B);
    pv(4'h0);
    set(32'h05);
    set(32'h0F);
    pv(4'h0);
    set(32'h01);
    set(32'h03);
    set(32'h02);
    chk(can_n, 3);
    pv(4'h4);
    set(32'h06);
    pv(4'h4);
    set(32'h0A);
    chk(can_n, 3);
    dly <= 16'h2;
    eaux <= 1'b1;
    set(32'h01);
    set(32'h03);
    chk({23'h0, av, acode}, 32'h15A);
    rdc(4'h4, 32'h48);
    set(32'h01);
    set(32'h03);
    rdc(4'h4, 32'h48);
    set(32'h4B);
    chk({23'h0, av, acode}, 32'h0);
    pv(4'h0);
    set(32'h01);
    set(32'h03);
    set(32'h43);
    eaux <= 1'b0;
    dly <= 16'hFFFF;
    set(32'h03);
    pv(4'h8);
    set(32'h0B);
    set(32'h41);
    eaux <= 1'b1;
    dly <= 16'h2;
    set(32'h43);
    chk({30'h0, run, av}, 32'h2);
    set(32'h49);
    chk(can_n, 4);
    pv(4'h8);
    report_and_stop;
  end
endmodule
